//--- logic/dcbfm_pkg.sv
// Shared constants for the dc-bus fault monitor: scaling, limits, map.
`default_nettype none
package dcbfm_pkg;

  localparam int DATA_W   = 32;
  localparam int SAMPLE_W = 16;
  localparam int COUNT_W  = 8;
  localparam int PERIOD_W = 16;
  localparam int IRQ_W    = 4;

  // Sample scaling: full-scale codes and the physical values they stand for.
  localparam real VOLTAGE_FULL_SCALE_V     = 407.0;
  localparam real CURRENT_FULL_SCALE_POS_A = 2.93;
  localparam real CURRENT_FULL_SCALE_NEG_A = -2.93;
  localparam real SENSE_FULL_SCALE_V       = 5.0;
  localparam real VOLTAGE_CODE_MAX         = 65535.0;
  localparam real CURRENT_CODE_MAX         = 32767.0;

  // Default limits in physical units.
  localparam real OVERVOLTAGE_LIMIT_V    = 380.0;
  localparam real UNDERVOLTAGE_LIMIT_V   = 100.0;
  localparam real MAINS_CLASS_V          = 150.0;
  localparam real OVERCURRENT_LIMIT_A    = 1.5;
  localparam real SENSE_OFFSET_NOMINAL_V = 1.65;
  localparam real SENSE_OFFSET_MARGIN_V  = 0.225;

  // Default limits converted to sample codes, rounded to nearest.
  localparam logic [SAMPLE_W-1:0] OV_LIMIT_RESET = SAMPLE_W'($rtoi(
    OVERVOLTAGE_LIMIT_V / VOLTAGE_FULL_SCALE_V * VOLTAGE_CODE_MAX + 0.5));
  localparam logic [SAMPLE_W-1:0] UV_LIMIT_RESET = SAMPLE_W'($rtoi(
    UNDERVOLTAGE_LIMIT_V / VOLTAGE_FULL_SCALE_V * VOLTAGE_CODE_MAX + 0.5));
  localparam logic [SAMPLE_W-1:0] MAINS_THR_RESET = SAMPLE_W'($rtoi(
    MAINS_CLASS_V / VOLTAGE_FULL_SCALE_V * VOLTAGE_CODE_MAX + 0.5));
  localparam logic [SAMPLE_W-1:0] OC_LIMIT_RESET = SAMPLE_W'($rtoi(
    OVERCURRENT_LIMIT_A / CURRENT_FULL_SCALE_POS_A * CURRENT_CODE_MAX
    + 0.5));
  localparam logic [SAMPLE_W-1:0] OFFSET_LIMIT_RESET = SAMPLE_W'($rtoi(
    (SENSE_OFFSET_NOMINAL_V + SENSE_OFFSET_MARGIN_V) / SENSE_FULL_SCALE_V
    * VOLTAGE_CODE_MAX + 0.5));
  localparam logic [COUNT_W-1:0]  OC_COUNT_RESET = 8'h04;

  // Current sampling period.
  localparam real CLOCK_MHZ         = 20.0;
  localparam real SAMPLE_PERIOD_US  = 128.0;
  localparam logic [PERIOD_W-1:0] SAMPLE_PERIOD_RESET = PERIOD_W'($rtoi(
    SAMPLE_PERIOD_US * CLOCK_MHZ));

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL         = 8'h00;
  localparam logic [7:0] ADDR_STATUS       = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h0c;
  localparam logic [7:0] ADDR_OV_LIMIT     = 8'h10;
  localparam logic [7:0] ADDR_UV_LIMIT     = 8'h14;
  localparam logic [7:0] ADDR_OC_LIMIT     = 8'h18;
  localparam logic [7:0] ADDR_OC_COUNT     = 8'h1c;
  localparam logic [7:0] ADDR_MAINS_THR    = 8'h20;
  localparam logic [7:0] ADDR_OFFSET_LIMIT = 8'h24;
  localparam logic [7:0] ADDR_PERIOD       = 8'h28;

  // Field positions.
  localparam int CTRL_MON_BIT    = 0;
  localparam int CTRL_PWM_BIT    = 1;
  localparam int CTRL_CALIB_BIT  = 2;
  localparam int ST_FAULT_BIT    = 0;
  localparam int ST_MAINS_BIT    = 1;
  localparam int ST_CALDONE_BIT  = 2;
  localparam int ST_PWM_BIT      = 3;
  localparam int ST_CALPEND_BIT  = 4;
  localparam int ST_COUNT_LSB    = 8;
  localparam int IRQ_OV_BIT      = 0;
  localparam int IRQ_UV_BIT      = 1;
  localparam int IRQ_OC_BIT      = 2;
  localparam int IRQ_OFFSET_BIT  = 3;

  localparam logic [1:0]        HTRANS_NONSEQ = 2'h2;
  localparam logic              HRESP_OKAY    = 1'h0;
  localparam logic [DATA_W-1:0] WORD_ZERO     = 32'h0000_0000;

endpackage
`default_nettype wire

//--- logic/dcbfm_sample_timer.sv
// Free-running timer that paces the current sampling requests.
`timescale 1ns/1ps
`default_nettype none
module dcbfm_sample_timer
  import dcbfm_pkg::*;
#(
  parameter int W = PERIOD_W
)
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] period,
  output logic              tick
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_tick;

  // A zero period is treated as one cycle so the timer never stalls.
  always_comb
  begin
    next_tick = (count == '0);
    if (count == '0)
      next_count = (period == '0) ? '0 : period - W'(1);
    else
      next_count = count - W'(1);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count <= W'(SAMPLE_PERIOD_RESET - PERIOD_W'(1));
      tick  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

  // Gap counter and period-change flag for checking the tick spacing.
  logic [W:0]   gap;
  logic         seen;
  logic         moved;
  logic [W-1:0] period_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gap      <= '0;
      seen     <= 1'b0;
      moved    <= 1'b0;
      period_q <= W'(SAMPLE_PERIOD_RESET);
    end
    else
    begin
      gap      <= tick ? (W+1)'(1) : gap + (W+1)'(1);
      seen     <= seen | tick;
      // A change wins over a tick, so a stale spacing is never judged.
      moved    <= (period != period_q) || (moved && !tick);
      period_q <= period;
    end
  end

  property p_tick_spacing;
    @(posedge hclk) disable iff (!hresetn)
    tick && seen && !moved && (period == period_q) && (period != '0)
    |-> gap == {1'b0, period};
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("Sample tick spacing differs from the period.");

endmodule
`default_nettype wire

//--- logic/dcbfm_oc_counter.sv
// Over-current persistence counter with reload on in-limit samples.
`timescale 1ns/1ps
`default_nettype none
module dcbfm_oc_counter
  import dcbfm_pkg::*;
#(
  parameter int W = COUNT_W
)
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] init_value,
  input  wire logic         evaluate,
  input  wire logic         over,
  output logic [W-1:0]      count,
  output logic              trip
);

  logic [W-1:0] next_count;

  // Trip on the sample that uses up the count; zero trips at once.
  assign trip = evaluate && over && (count <= W'(1));

  // Down on each over-limit sample until zero, then hold; reload on any sample at or below.
  always_comb
  begin
    next_count = count;
    if (evaluate && over && (count != '0))
      next_count = count - W'(1);
    else if (evaluate && !over)
      next_count = init_value;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= W'(OC_COUNT_RESET);
    else
      count <= next_count;
  end

  property p_reload;
    @(posedge hclk) disable iff (!hresetn)
    evaluate && !over |=> count == $past(init_value);
  endproperty
  a_reload: assert property (p_reload)
    else $error("Counter did not reload after an in-limit sample.");

endmodule
`default_nettype wire

//--- logic/dcbfm_top.sv
// Dc-bus fault monitor: limit checks, calibration, mains class, AHB regs.
//
// Function
// - Fault when bus voltage exceeds upper limit.
// - Fault when bus voltage drops below lower limit.
// - Fault after programmed count of over-current samples.
// - Sample and check current every 128 us.
// - Count is unsigned, initial values zero to 255.
// - Offset check with outputs off; fault if high.
// - Classify mains by threshold; nothing else changes.
// - Zero threshold on low-voltage boards disables class.
// - Voltage full scale is 407 V, configurable.
// - Current is signed, full scale plus/minus 2.93 A.
// - Upper voltage limit clamps to power-stage limit.
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module dcbfm_top
  import dcbfm_pkg::*;
#(
  parameter logic [SAMPLE_W-1:0] OV_STAGE_LIMIT = OV_LIMIT_RESET
)
(
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [DATA_W-1:0]   hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [DATA_W-1:0]        hrdata,
  output logic                     hresp,
  output logic                     sample_req,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] voltage_sample,
  input  wire logic [SAMPLE_W-1:0] current_sample,
  input  wire logic [SAMPLE_W-1:0] sense_offset_sample,
  output logic                     pwm_enable,
  output logic                     fault,
  output logic                     mains_230,
  output logic                     irq
);

  // Register state.
  logic                ctrl_mon;
  logic                ctrl_pwm;
  logic [IRQ_W-1:0]    irq_status;
  logic [IRQ_W-1:0]    irq_mask;
  logic [SAMPLE_W-1:0] overvoltage_limit;
  logic [SAMPLE_W-1:0] undervoltage_limit;
  logic [SAMPLE_W-1:0] overcurrent_limit;
  logic [COUNT_W-1:0]  overcurrent_sample_count;
  logic [SAMPLE_W-1:0] mains_class_threshold;
  logic [SAMPLE_W-1:0] sense_offset_fault_limit;
  logic [PERIOD_W-1:0] current_sample_period;
  logic                wr_pend;
  logic                rd_pend;
  logic [7:0]          data_addr;
  logic                calib_pend;
  logic                calib_done;
  logic                next_ctrl_mon;
  logic                next_ctrl_pwm;
  logic [IRQ_W-1:0]    next_irq_status;
  logic [IRQ_W-1:0]    next_irq_mask;
  logic [SAMPLE_W-1:0] next_overvoltage_limit;
  logic [SAMPLE_W-1:0] next_undervoltage_limit;
  logic [SAMPLE_W-1:0] next_overcurrent_limit;
  logic [COUNT_W-1:0]  next_overcurrent_sample_count;
  logic [SAMPLE_W-1:0] next_mains_class_threshold;
  logic [SAMPLE_W-1:0] next_sense_offset_fault_limit;
  logic [PERIOD_W-1:0] next_current_sample_period;
  logic                next_wr_pend;
  logic                next_rd_pend;
  logic [7:0]          next_data_addr;
  logic                next_calib_pend;
  logic                next_calib_done;
  logic                next_fault;
  logic                next_mains_230;
  logic                next_pwm_enable;

  // Monitor events decoded from the current sample.
  logic               evaluate;
  logic               over_voltage;
  logic               under_voltage;
  logic               over_current;
  logic               oc_trip;
  logic               offset_bad;
  logic               calib_now;
  logic [IRQ_W-1:0]   irq_set;
  logic [COUNT_W-1:0] oc_count;

  dcbfm_sample_timer #(
    .W (PERIOD_W)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .period  (current_sample_period),
    .tick    (sample_req)
  );

  // Limit checks run only on samples taken while monitoring is on; the offset check does not need it.
  assign evaluate      = sample_valid && ctrl_mon;
  assign over_voltage  = evaluate && (voltage_sample > overvoltage_limit);
  assign under_voltage = evaluate && (voltage_sample < undervoltage_limit);
  // Current is two's complement; a negative sample can trip only if the limit is negative.
  assign over_current  = $signed(current_sample)
                         > $signed(overcurrent_limit);
  // Calibration waits for a sample taken with the outputs off.
  assign calib_now     = sample_valid && calib_pend && !pwm_enable;
  assign offset_bad    = calib_now
                         && (sense_offset_sample
                             > sense_offset_fault_limit);
  assign irq_set = {offset_bad, oc_trip, under_voltage, over_voltage};
  assign irq     = |(irq_status & irq_mask);

  dcbfm_oc_counter #(
    .W (COUNT_W)
  ) u_oc_counter (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .init_value (overcurrent_sample_count),
    .evaluate   (evaluate),
    .over       (over_current),
    .count      (oc_count),
    .trip       (oc_trip)
  );

  // Zero-wait AHB-Lite slave, always OKAY; unmapped reads give zero.
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  always_comb
  begin
    hrdata = WORD_ZERO;
    if (rd_pend)
      unique case (data_addr)
        ADDR_CTRL:
          hrdata[CTRL_PWM_BIT:CTRL_MON_BIT] = {ctrl_pwm, ctrl_mon};
        ADDR_STATUS:
        begin
          hrdata[ST_FAULT_BIT]   = fault;
          hrdata[ST_MAINS_BIT]   = mains_230;
          hrdata[ST_CALDONE_BIT] = calib_done;
          hrdata[ST_PWM_BIT]     = pwm_enable;
          hrdata[ST_CALPEND_BIT] = calib_pend;
          hrdata[ST_COUNT_LSB +: COUNT_W] = oc_count;
        end
        ADDR_IRQ_STATUS:   hrdata[IRQ_W-1:0]    = irq_status;
        ADDR_IRQ_MASK:     hrdata[IRQ_W-1:0]    = irq_mask;
        ADDR_OV_LIMIT:     hrdata[SAMPLE_W-1:0] = overvoltage_limit;
        ADDR_UV_LIMIT:     hrdata[SAMPLE_W-1:0] = undervoltage_limit;
        ADDR_OC_LIMIT:     hrdata[SAMPLE_W-1:0] = overcurrent_limit;
        ADDR_OC_COUNT:     hrdata[COUNT_W-1:0]  = overcurrent_sample_count;
        ADDR_MAINS_THR:    hrdata[SAMPLE_W-1:0] = mains_class_threshold;
        ADDR_OFFSET_LIMIT: hrdata[SAMPLE_W-1:0] = sense_offset_fault_limit;
        ADDR_PERIOD:       hrdata[PERIOD_W-1:0] = current_sample_period;
        default:           hrdata = WORD_ZERO;
      endcase
  end

  // Next values of the register file and the bus pipeline.
  always_comb
  begin
    next_wr_pend = hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite;
    next_rd_pend = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;
    next_data_addr = (hsel && hready) ? haddr[7:0] : data_addr;
    next_ctrl_mon  = ctrl_mon;
    next_ctrl_pwm  = ctrl_pwm;
    next_irq_mask  = irq_mask;
    next_overvoltage_limit        = overvoltage_limit;
    next_undervoltage_limit       = undervoltage_limit;
    next_overcurrent_limit        = overcurrent_limit;
    next_overcurrent_sample_count = overcurrent_sample_count;
    next_mains_class_threshold    = mains_class_threshold;
    next_sense_offset_fault_limit = sense_offset_fault_limit;
    next_current_sample_period    = current_sample_period;
    next_calib_pend = calib_pend && !calib_now;
    next_calib_done = calib_done || calib_now;
    // A new event in the clearing cycle survives: set wins.
    next_irq_status = irq_status | irq_set;
    if (wr_pend)
    begin
      unique case (data_addr)
        ADDR_CTRL:
        begin
          next_ctrl_mon = hwdata[CTRL_MON_BIT];
          next_ctrl_pwm = hwdata[CTRL_PWM_BIT];
          if (hwdata[CTRL_CALIB_BIT])
          begin
            next_calib_pend = 1'b1;
            next_calib_done = 1'b0;
          end
        end
        ADDR_IRQ_STATUS:
          next_irq_status = (irq_status & ~hwdata[IRQ_W-1:0]) | irq_set;
        ADDR_IRQ_MASK: next_irq_mask = hwdata[IRQ_W-1:0];
        // Writes above the power-stage ceiling are clamped to it.
        ADDR_OV_LIMIT:
          next_overvoltage_limit =
            (hwdata[SAMPLE_W-1:0] > OV_STAGE_LIMIT)
            ? OV_STAGE_LIMIT : hwdata[SAMPLE_W-1:0];
        ADDR_UV_LIMIT:  next_undervoltage_limit  = hwdata[SAMPLE_W-1:0];
        ADDR_OC_LIMIT:  next_overcurrent_limit   = hwdata[SAMPLE_W-1:0];
        ADDR_OC_COUNT:
          next_overcurrent_sample_count = hwdata[COUNT_W-1:0];
        ADDR_MAINS_THR: next_mains_class_threshold = hwdata[SAMPLE_W-1:0];
        ADDR_OFFSET_LIMIT:
          next_sense_offset_fault_limit = hwdata[SAMPLE_W-1:0];
        ADDR_PERIOD:
          next_current_sample_period = hwdata[PERIOD_W-1:0];
        default: next_ctrl_mon = ctrl_mon;
      endcase
    end
  end

  // Fault latch, mains class and drive enable.
  always_comb
  begin
    next_fault = fault || over_voltage || under_voltage
                 || oc_trip || offset_bad;
    next_mains_230 = mains_230;
    // The class is informational only; it feeds no other decision.
    // A zero threshold clears the class at once, not at the next sample.
    if (mains_class_threshold == '0)
      next_mains_230 = 1'b0;
    else if (sample_valid)
      next_mains_230 = voltage_sample > mains_class_threshold;
    // Outputs stay off while faulted or while an offset check is pending.
    next_pwm_enable = next_ctrl_pwm && !next_fault
                      && !next_calib_pend;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend    <= 1'b0;
      rd_pend    <= 1'b0;
      data_addr  <= ADDR_CTRL;
      ctrl_mon   <= 1'b0;
      ctrl_pwm   <= 1'b0;
      irq_status <= '0;
      irq_mask   <= '0;
      overvoltage_limit        <= OV_LIMIT_RESET;
      undervoltage_limit       <= UV_LIMIT_RESET;
      overcurrent_limit        <= OC_LIMIT_RESET;
      overcurrent_sample_count <= OC_COUNT_RESET;
      mains_class_threshold    <= MAINS_THR_RESET;
      sense_offset_fault_limit <= OFFSET_LIMIT_RESET;
      current_sample_period    <= SAMPLE_PERIOD_RESET;
      calib_pend <= 1'b0;
      calib_done <= 1'b0;
      fault      <= 1'b0;
      mains_230  <= 1'b0;
      pwm_enable <= 1'b0;
    end
    else
    begin
      wr_pend    <= next_wr_pend;
      rd_pend    <= next_rd_pend;
      data_addr  <= next_data_addr;
      ctrl_mon   <= next_ctrl_mon;
      ctrl_pwm   <= next_ctrl_pwm;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      overvoltage_limit        <= next_overvoltage_limit;
      undervoltage_limit       <= next_undervoltage_limit;
      overcurrent_limit        <= next_overcurrent_limit;
      overcurrent_sample_count <= next_overcurrent_sample_count;
      mains_class_threshold    <= next_mains_class_threshold;
      sense_offset_fault_limit <= next_sense_offset_fault_limit;
      current_sample_period    <= next_current_sample_period;
      calib_pend <= next_calib_pend;
      calib_done <= next_calib_done;
      fault      <= next_fault;
      mains_230  <= next_mains_230;
      pwm_enable <= next_pwm_enable;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_over_limit_run;
    (evaluate && over_current && oc_count == 8'h01);
  endsequence
  property p_overvoltage;
    evaluate && (voltage_sample > overvoltage_limit) |=> fault && !pwm_enable;
  endproperty
  a_overvoltage: assert property (p_overvoltage)
    else $error("Over-voltage sample did not raise the fault.");
  property p_undervoltage;
    evaluate && (voltage_sample < undervoltage_limit) |=> fault;
  endproperty
  a_undervoltage: assert property (p_undervoltage)
    else $error("Under-voltage sample did not raise the fault.");
  property p_overcurrent;
    s_over_limit_run |=> fault ##0 irq_status[IRQ_OC_BIT];
  endproperty
  a_overcurrent: assert property (p_overcurrent)
    else $error("Last counted over-current sample did not fault.");
  property p_no_early_trip;
    evaluate && over_current && oc_count > 8'h01 && !fault
    && !over_voltage && !under_voltage && !offset_bad |=> !fault;
  endproperty
  a_no_early_trip: assert property (p_no_early_trip)
    else $error("Over-current fault came before the count ran out.");
  property p_offset;
    sample_valid && calib_pend && !pwm_enable
    && (sense_offset_sample > sense_offset_fault_limit)
    |=> fault ##0 calib_done ##0 !calib_pend;
  endproperty
  a_offset: assert property (p_offset)
    else $error("High sense offset during calibration did not fault.");
  property p_mains_zero;
    mains_class_threshold == '0 |=> !mains_230;
  endproperty
  a_mains_zero: assert property (p_mains_zero)
    else $error("Mains class set while the threshold is zero.");
  property p_mains_class;
    sample_valid && (mains_class_threshold != '0)
    |=> mains_230 == ($past(voltage_sample) > $past(mains_class_threshold));
  endproperty
  a_mains_class: assert property (p_mains_class)
    else $error("Mains class does not follow the bus voltage.");
  property p_ov_clamp;
    overvoltage_limit <= OV_STAGE_LIMIT;
  endproperty
  a_ov_clamp: assert property (p_ov_clamp)
    else $error("Upper voltage limit exceeds the power-stage ceiling.");
  property p_fault_latched;
    fault |=> fault [*8] ##0 !pwm_enable;
  endproperty
  a_fault_latched: assert property (p_fault_latched)
    else $error("Fault released or outputs enabled while faulted.");

endmodule
`default_nettype wire

//--- testbench/dcbfm_afe_model.sv
// Analogue sensing front end model that answers sample requests.
`timescale 1ns/1ps
`default_nettype none
module dcbfm_afe_model
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        sample_req,
  input  wire logic        en,
  input  wire logic [1:0]  delay,
  input  wire logic [47:0] smp,
  output logic             sample_valid,
  output logic [47:0]      data
);
  logic       busy;
  logic [1:0] cnt;
  // Data toggles outside a valid pulse so a stale value never passes.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      busy         <= 1'b0;
      cnt          <= 2'h0;
      sample_valid <= 1'b0;
      data         <= 48'h0000_0000_0000;
    end
    else
    begin
      sample_valid <= busy && cnt == 2'h0;
      data         <= (busy && cnt == 2'h0) ? smp : ~data;
      cnt          <= cnt - 2'h1;
      if (busy && cnt == 2'h0)
        busy <= 1'b0;
      else if (!busy && sample_req && en)
      begin
        busy <= 1'b1;
        cnt  <= delay;
      end
    end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the dc-bus fault monitor.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dcbfm_pkg::*;
  logic        hclk, hresetn, hwrite, en, sample_valid, hreadyout;
  logic        hresp, sample_req, pwm_enable, fault, mains_230, irq;
  logic [1:0]  htrans, delay;
  logic [31:0] haddr, hwdata, hrdata, rd_q;
  logic [47:0] smp, afe;
  int          n_errors, n_checks;

  dcbfm_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .sample_req(sample_req),
    .sample_valid(sample_valid), .voltage_sample(afe[47:32]),
    .current_sample(afe[31:16]), .sense_offset_sample(afe[15:0]),
    .pwm_enable(pwm_enable), .fault(fault), .mains_230(mains_230),
    .irq(irq));
  dcbfm_afe_model u_afe (.hclk(hclk), .hresetn(hresetn),
    .sample_req(sample_req), .en(en), .delay(delay), .smp(smp),
    .sample_valid(sample_valid), .data(afe));

  // Read data is captured at the edge that closes the data phase.
  always_ff @(posedge hclk)
    rd_q <= hrdata;

  task automatic test_done;
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %0t: word %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %0t: pin %b, want %b", $time, got, exp);
    end
  endtask
  // One single transfer; the bus slave may stretch either phase.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    haddr  <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    @(negedge hclk);
    q = rd_q;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] q;
    bus(1'b0, a, WORD_ZERO, q);
    chk_reg(q & m, e);
    chk_pin(hresp, HRESP_OKAY);
  endtask
  task automatic rst;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  // Short period so that each scenario sees samples quickly.
  task automatic setup(input logic [31:0] ctrl);
    rst();
    wr(ADDR_PERIOD, 32'h0000_0008);
    wr(ADDR_IRQ_MASK, 32'h0000_000f);
    wr(ADDR_CTRL, ctrl);
  endtask
  // Hands one sample set to the front end and waits until it is taken.
  task automatic send(input logic [15:0] v, c, o);
    @(posedge hclk);
    smp <= {v, c, o};
    en  <= 1'b1;
    for (int i = 0; i < 3000 && sample_valid !== 1'b1; i++) @(negedge hclk);
    chk_pin(sample_valid, 1'b1);
    @(posedge hclk);
    en <= 1'b0;
    @(negedge hclk);
  endtask
  task automatic gap(input int exp);
    int n;
    for (n = 0; n < 6000 && sample_req !== 1'b1; n++) @(negedge hclk);
    @(negedge hclk);
    for (n = 1; n < 6000 && sample_req !== 1'b1; n++) @(negedge hclk);
    chk_reg(32'(n), 32'(exp));
  endtask

  task automatic t_defaults;
    rst();
    chk_pin(fault, 1'b0);
    rd(ADDR_OV_LIMIT, 32'h0000_ef03);
    rd(ADDR_UV_LIMIT, 32'h0000_3ee6);
    rd(ADDR_OC_LIMIT, 32'h0000_4187);
    rd(ADDR_OC_COUNT, 32'h0000_0004);
    rd(ADDR_MAINS_THR, 32'h0000_5e59);
    rd(ADDR_OFFSET_LIMIT, 32'h0000_6000);
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h3c, WORD_ZERO);
    wr(ADDR_OV_LIMIT, 32'h0000_ffff);
    rd(ADDR_OV_LIMIT, 32'h0000_ef03);
    gap(2560);
  endtask
  // A value on the limit passes; one step beyond it faults for good.
  task automatic t_volt(input logic [15:0] ok_v, bad_v,
                        input logic [31:0] bit_e);
    setup(32'h0000_0003);
    delay <= 2'h3;
    send(ok_v, 16'h0000, 16'h5000);
    chk_pin(pwm_enable, 1'b1);
    send(bad_v, 16'h0000, 16'h5000);
    chk_pin(fault, 1'b1);
    chk_pin(pwm_enable, 1'b0);
    chk_pin(irq, 1'b1);
    wr(ADDR_IRQ_STATUS, bit_e);
    chk_pin(irq, 1'b0);
    wr(ADDR_IRQ_MASK, WORD_ZERO);
    send(bad_v, 16'h0000, 16'h5000);
    chk_pin(irq, 1'b0);
    rd(ADDR_IRQ_STATUS, bit_e);
    chk_pin(fault, 1'b1);
    delay <= 2'h0;
  endtask
  task automatic t_oc;
    setup(32'h0000_0003);
    for (int i = 0; i < 2; i++)
    begin
      repeat (3) send(16'h8000, 16'h4188, 16'h5000);
      rd(ADDR_STATUS, 32'h0000_0100, 32'h0000_ff01);
      send(16'h8000, i ? 16'h8001 : 16'h4187, 16'h5000);
      rd(ADDR_STATUS, 32'h0000_0400, 32'h0000_ff01);
    end
    repeat (3) send(16'h8000, 16'h7fff, 16'h5000);
    chk_pin(fault, 1'b0);
    send(16'h8000, 16'h7fff, 16'h5000);
    chk_pin(fault, 1'b1);
    rd(ADDR_IRQ_STATUS, 32'h0000_0004);
  endtask
  task automatic t_cnt(input logic [7:0] n);
    setup(32'h0000_0003);
    wr(ADDR_OC_COUNT, {24'h00_0000, n});
    send(16'h8000, 16'h0000, 16'h5000);
    repeat (n > 8'h01 ? n - 8'h01 : 0) send(16'h8000, 16'h4188, 16'h5000);
    chk_pin(fault, 1'b0);
    send(16'h8000, 16'h4188, 16'h5000);
    chk_pin(fault, 1'b1);
  endtask
  task automatic t_mains;
    setup(32'h0000_0000);
    send(16'h5e5a, 16'h0000, 16'h5000);
    chk_pin(mains_230, 1'b1);
    send(16'h5e50, 16'h0000, 16'h5000);
    chk_pin(mains_230, 1'b0);
    chk_pin(fault, 1'b0);
    send(16'h5e5a, 16'h0000, 16'h5000);
    wr(ADDR_MAINS_THR, WORD_ZERO);
    @(negedge hclk);
    chk_pin(mains_230, 1'b0);
    send(16'hffff, 16'h0000, 16'h5000);
    chk_pin(mains_230, 1'b0);
  endtask
  task automatic t_offset;
    setup(32'h0000_0004);
    send(16'h8000, 16'h0000, 16'h6000);
    chk_pin(fault, 1'b0);
    rd(ADDR_STATUS, 32'h0000_0004, 32'h0000_0015);
    wr(ADDR_CTRL, 32'h0000_0004);
    send(16'h8000, 16'h0000, 16'h6001);
    chk_pin(fault, 1'b1);
    rd(ADDR_IRQ_STATUS, 32'h0000_0008);
  endtask

  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // Longest expected run is well under this span.
  initial
  begin
    #4_000_000;
    n_errors++;
    test_done();
  end
  initial
  begin
    {hresetn, hwrite, en, htrans, delay} = '0;
    {haddr, hwdata, smp} = '0;
    t_defaults();
    t_volt(16'hef03, 16'hef04, 32'h0000_0001);
    t_volt(16'h3ee6, 16'h3ee5, 32'h0000_0002);
    t_oc();
    t_cnt(8'h00);
    t_cnt(8'hff);
    t_mains();
    t_offset();
    test_done();
  end
endmodule
`default_nettype wire
